// >>> core/fcs_defines.vh
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
`define FCS_ST2_CM_BIT 6
`define FCS_ST2_DD_BIT 5
`define FCS_ST2_WC_BIT 4
`define FCS_ST2_BC_BIT 1
`define FCS_ST2_MD_BIT 0
`define FCS_ST3_WP_BIT 6
`define FCS_ST3_T0_BIT 4
`define FCS_ST3_HD_BIT 2
`define FCS_BAD_TRACK 8'hFF
`define FCS_MODE_LSB 2
`define FCS_BURST_BIT 1
`define FCS_MODE_AT 2'h0
`define FCS_MODE_PS2 2'h1
`define FCS_MODE_M30 2'h2
`define FCS_DOR_RST_BIT 2
`define FCS_DOR_DMA_BIT 3
`define FCS_FIFO_DEPTH 5'h10
`define FCS_PROC_CYCLES 2'h2
`define FCS_ST3_FIXED 8'h28
`endif

// >>> core/fcs_status_two.v
`timescale 1ns/100ps
`include "fcs_defines.vh"
module fcs_status_two (
    input wire clk_sys_in,
    input wire rst_in,
    // clear and events
    input wire clear_in,
    input wire ev_mark_kind_in,
    input wire read_deleted_in,
    input wire ev_crc_bad_in,
    input wire ev_id_in,
    input wire [7:0] id_track_in,
    input wire [7:0] kept_track_in,
    input wire ev_no_mark_in,
    // value
    output wire [7:0] status_two_out
);
    reg control_mark_flag_q;
    reg data_field_crc_flag_q;
    reg wrong_track_flag_q;
    reg bad_track_flag_q;
    reg missing_data_mark_flag_q;
    wire mismatch;
    wire mark_wrong;
    assign mismatch = ev_id_in && (id_track_in != kept_track_in);
    // mark_kind 1 = deleted mark seen
    assign mark_wrong = ev_mark_kind_in ^ read_deleted_in;
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            control_mark_flag_q <= 1'b0;
            data_field_crc_flag_q <= 1'b0;
            wrong_track_flag_q <= 1'b0;
            bad_track_flag_q <= 1'b0;
            missing_data_mark_flag_q <= 1'b0;
        end else begin
            // set wins over clear
            control_mark_flag_q <= (control_mark_flag_q && !clear_in)
                || mark_wrong;
            data_field_crc_flag_q <= (data_field_crc_flag_q && !clear_in)
                || ev_crc_bad_in;
            wrong_track_flag_q <= (wrong_track_flag_q && !clear_in) || mismatch;
            bad_track_flag_q <= (bad_track_flag_q && !clear_in)
                || (mismatch && id_track_in == `FCS_BAD_TRACK);
            missing_data_mark_flag_q <= (missing_data_mark_flag_q && !clear_in)
                || ev_no_mark_in;
        end
    end
    assign status_two_out = {1'b0, control_mark_flag_q, data_field_crc_flag_q,
        wrong_track_flag_q, 2'b00, bad_track_flag_q, missing_data_mark_flag_q};
endmodule // fcs_status_two

// >>> core/fcs_fifo_ctrl.v
`timescale 1ns/100ps
`include "fcs_defines.vh"
module fcs_fifo_ctrl (
    input wire clk_sys_in,
    input wire rst_in,
    // control
    input wire enable_in,
    input wire [3:0] fifo_threshold_param_in,
    input wire to_host_in,
    input wire sector_last_in,
    // fill level
    input wire [4:0] level_in,
    // request
    output wire [4:0] threshold_out,
    output reg dma_request_out
);
    wire [4:0] thr;
    wire [4:0] hi_mark;
    assign thr = {1'b0, fifo_threshold_param_in} + 5'h01;
    assign threshold_out = thr;
    assign hi_mark = `FCS_FIFO_DEPTH - thr;
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dma_request_out <= 1'b0;
        end else if (!enable_in) begin
            dma_request_out <= 1'b0;
        end else if (to_host_in) begin
            if (level_in >= hi_mark || sector_last_in) begin
                dma_request_out <= 1'b1;
            end else if (level_in == 5'h00) begin
                dma_request_out <= 1'b0;
            end
        end else begin
            if (level_in == `FCS_FIFO_DEPTH) begin
                dma_request_out <= 1'b0;
            end else if (`FCS_FIFO_DEPTH - level_in >= thr) begin
                dma_request_out <= 1'b1;
            end
        end
    end
endmodule // fcs_fifo_ctrl

// >>> core/fcs_core.v
`timescale 1ns/100ps
`include "fcs_defines.vh"
module fcs_core (
    input wire clk_sys_in,
    input wire rst_in,
    // host register writes
    input wire dor_wr_in,
    input wire [7:0] dor_data_in,
    input wire dsr_wr_in,
    input wire dsr_reset_in,
    input wire [7:0] logical_device_config_reg_in,
    // command bytes
    input wire cmd_wr_in,
    input wire [7:0] cmd_data_in,
    input wire result_rd_in,
    // configure and specify results from decoder
    input wire cfg_load_in,
    input wire cfg_fifo_en_in,
    input wire [3:0] cfg_thr_in,
    input wire cfg_poll_off_in,
    input wire spec_load_in,
    input wire spec_dma_in,
    // execution events
    input wire exec_done_in,
    input wire ev_mark_kind_in,
    input wire read_deleted_in,
    input wire ev_crc_bad_in,
    input wire ev_id_in,
    input wire [7:0] id_track_in,
    input wire [7:0] kept_track_in,
    input wire ev_no_mark_in,
    input wire to_host_in,
    input wire sector_last_in,
    input wire [4:0] fifo_level_in,
    input wire irq_raw_in,
    // drive pins
    input wire write_protect_in,
    input wire track_zero_input_in,
    input wire head_sel_in,
    input wire [1:0] drive_sel_in,
    // status
    output wire [7:0] result_status_two_out,
    output wire [7:0] result_status_three_out,
    output wire request_for_master_flag_out,
    output wire transfer_direction_flag_out,
    output wire core_reset_out,
    output wire power_down_exit_out,
    output wire polling_on_out,
    // host side gates
    output reg dma_request_out,
    output reg irq_out,
    output wire burst_mode_out,
    output reg density_select_output_out,
    input wire high_density_in,
    output wire [4:0] threshold_out
);
    localparam PH_CMD = 4'b0001;
    localparam PH_BUSY = 4'b0010;
    localparam PH_EXEC = 4'b0100;
    localparam PH_RES = 4'b1000;

    reg [2:0] wp_sync_q;
    reg [2:0] t0_sync_q;
    reg wp_q;
    reg t0_q;
    reg [7:0] dor_q;
    reg dsr_rst_q;
    reg spec_dma_q;
    reg fifo_en_q;
    reg [3:0] thr_q;
    reg poll_off_q;
    reg [3:0] phase_q;
    reg [3:0] bytes_left_q;
    reg [1:0] proc_cnt_q;
    reg illegal_q;
    reg [3:0] res_left_q;
    reg start_q;
    reg gate_sel;
    reg density_low;
    reg [7:0] st3_val;
    wire soft_rst;
    wire [1:0] mode;
    wire gate_on;
    wire fifo_req;
    wire [3:0] need;
    wire known;

    // pin reset clears the output-register reset bit (active low bit = 0 held)
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dor_q <= 8'h00;
        end else if (dor_wr_in) begin
            dor_q <= dor_data_in;
        end
    end

    // rate-register reset lasts one cycle then clears itself
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dsr_rst_q <= 1'b0;
        end else begin
            dsr_rst_q <= dsr_wr_in && dsr_reset_in;
        end
    end

    // reset bit low means held in reset; either register alone holds the core in reset
    assign soft_rst = !dor_q[`FCS_DOR_RST_BIT] || dsr_rst_q;
    assign core_reset_out = soft_rst;
    assign power_down_exit_out = soft_rst;

    // specify settings survive soft resets and pin reset
    always @(posedge clk_sys_in) begin
        if (spec_load_in) begin
            spec_dma_q <= spec_dma_in;
        end
    end

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fifo_en_q <= 1'b0;
            thr_q <= 4'h0;
            poll_off_q <= 1'b0;
        end else if (soft_rst) begin
            fifo_en_q <= 1'b0;
            thr_q <= 4'h0;
            poll_off_q <= 1'b0;
        end else if (cfg_load_in) begin
            fifo_en_q <= cfg_fifo_en_in;
            thr_q <= cfg_thr_in;
            poll_off_q <= cfg_poll_off_in;
        end
    end
    assign polling_on_out = !poll_off_q;

    // pin synchronisers, change counts when stages two and three agree
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wp_sync_q <= 3'h0;
            t0_sync_q <= 3'h0;
            wp_q <= 1'b0;
            t0_q <= 1'b0;
        end else begin
            wp_sync_q <= {wp_sync_q[1:0], write_protect_in};
            t0_sync_q <= {t0_sync_q[1:0], track_zero_input_in};
            if (wp_sync_q[1] == wp_sync_q[2]) begin
                wp_q <= wp_sync_q[2];
            end
            if (t0_sync_q[1] == t0_sync_q[2]) begin
                t0_q <= t0_sync_q[2];
            end
        end
    end

    // status three: fixed ones with synchronised write-protect and track-zero levels and live head and drive pins laid over them
    always @* begin
        st3_val = `FCS_ST3_FIXED;
        st3_val[`FCS_ST3_WP_BIT] = wp_q;
        st3_val[`FCS_ST3_T0_BIT] = t0_q;
        st3_val[`FCS_ST3_HD_BIT] = head_sel_in;
        st3_val[1:0] = drive_sel_in;
    end
    assign result_status_three_out = st3_val;

    // command length lookup; only opcodes with low five bits zero are illegal, other unlisted ones take 8 bytes
    assign known = (cmd_data_in[4:0] != 5'h00);
    assign need = (cmd_data_in[4:0] == 5'h13) ? 4'h3 :
        (cmd_data_in[4:0] == 5'h03) ? 4'h2 :
        (cmd_data_in[4:0] == 5'h08) ? 4'h0 : 4'h8;

    // command phase sequencer
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= PH_CMD;
            bytes_left_q <= 4'h0;
            proc_cnt_q <= 2'h0;
            illegal_q <= 1'b0;
            res_left_q <= 4'h0;
            start_q <= 1'b0;
        end else if (soft_rst) begin
            phase_q <= PH_CMD;
            bytes_left_q <= 4'h0;
            proc_cnt_q <= 2'h0;
            illegal_q <= 1'b0;
            res_left_q <= 4'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (phase_q)
                PH_CMD: begin
                    if (cmd_wr_in) begin
                        phase_q <= PH_BUSY;
                        proc_cnt_q <= `FCS_PROC_CYCLES;
                        if (bytes_left_q == 4'h0) begin
                            start_q <= 1'b1;
                            illegal_q <= !known;
                            bytes_left_q <= known ? need : 4'h0;
                        end else begin
                            bytes_left_q <= bytes_left_q - 4'h1;
                        end
                    end
                end
                PH_BUSY: begin
                    if (proc_cnt_q != 2'h0) begin
                        proc_cnt_q <= proc_cnt_q - 2'h1;
                    end else if (illegal_q) begin
                        phase_q <= PH_RES;
                        res_left_q <= 4'h1;
                        illegal_q <= 1'b0;
                    end else if (bytes_left_q != 4'h0) begin
                        phase_q <= PH_CMD;
                    end else begin
                        phase_q <= PH_EXEC;
                    end
                end
                PH_EXEC: begin
                    if (exec_done_in) begin
                        phase_q <= PH_RES;
                        res_left_q <= 4'h7;
                    end
                end
                PH_RES: begin
                    if (result_rd_in) begin
                        if (res_left_q == 4'h1) begin
                            phase_q <= PH_CMD;
                        end
                        res_left_q <= res_left_q - 4'h1;
                    end
                end
                default: begin
                    phase_q <= PH_CMD;
                end
            endcase
        end
    end

    assign request_for_master_flag_out = (phase_q == PH_CMD) || (phase_q == PH_RES);
    assign transfer_direction_flag_out = (phase_q == PH_RES);

    fcs_status_two u_st2 (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clear_in(start_q || soft_rst),
        .ev_mark_kind_in(ev_mark_kind_in),
        .read_deleted_in(read_deleted_in),
        .ev_crc_bad_in(ev_crc_bad_in),
        .ev_id_in(ev_id_in),
        .id_track_in(id_track_in),
        .kept_track_in(kept_track_in),
        .ev_no_mark_in(ev_no_mark_in),
        .status_two_out(result_status_two_out)
    );

    fcs_fifo_ctrl u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .enable_in(fifo_en_q && phase_q == PH_EXEC && !soft_rst),
        .fifo_threshold_param_in(thr_q),
        .to_host_in(to_host_in),
        .sector_last_in(sector_last_in),
        .level_in(fifo_level_in),
        .threshold_out(threshold_out),
        .dma_request_out(fifo_req)
    );

    // interface mode gating of interrupt, DMA and density polarity
    assign mode = logical_device_config_reg_in[`FCS_MODE_LSB+1:`FCS_MODE_LSB];
    // reserved code 3 behaves like the third mode
    always @* begin
        gate_sel = dor_q[`FCS_DOR_DMA_BIT];
        density_low = 1'b1;
        case (mode)
            `FCS_MODE_AT: begin
                gate_sel = dor_q[`FCS_DOR_DMA_BIT];
                density_low = 1'b0;
            end
            `FCS_MODE_PS2: begin
                gate_sel = 1'b1;
                density_low = 1'b1;
            end
            `FCS_MODE_M30: begin
                gate_sel = dor_q[`FCS_DOR_DMA_BIT];
                density_low = 1'b1;
            end
            default: begin
                gate_sel = dor_q[`FCS_DOR_DMA_BIT];
                density_low = 1'b1;
            end
        endcase
    end
    assign gate_on = gate_sel;
    assign burst_mode_out = logical_device_config_reg_in[`FCS_BURST_BIT];

    // outputs registered so mode changes land on a clock edge
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dma_request_out <= 1'b0;
            irq_out <= 1'b0;
            density_select_output_out <= 1'b1;
        end else begin
            dma_request_out <= fifo_req && gate_on && spec_dma_q;
            irq_out <= irq_raw_in && gate_on;
            density_select_output_out <= high_density_in ^ density_low;
        end
    end
endmodule // fcs_core

// >>> sim/fcs_core_props.sv
`timescale 1ns/100ps
module fcs_core_props (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_in,
    // watched inputs
    input wire dor_wr_in,
    input wire [7:0] dor_data_in,
    input wire dsr_wr_in,
    input wire dsr_reset_in,
    input wire [7:0] logical_device_config_reg_in,
    input wire cmd_wr_in,
    input wire ev_crc_bad_in,
    input wire ev_id_in,
    input wire [7:0] id_track_in,
    input wire [7:0] kept_track_in,
    input wire ev_no_mark_in,
    input wire head_sel_in,
    input wire [1:0] drive_sel_in,
    input wire high_density_in,
    // watched outputs
    input wire [7:0] result_status_two_out,
    input wire [7:0] result_status_three_out,
    input wire request_for_master_flag_out,
    input wire transfer_direction_flag_out,
    input wire core_reset_out,
    input wire burst_mode_out,
    input wire density_select_output_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    // inverted mirror of the output-register reset bit
    reg dor_rst_q;
    wire [1:0] mode = logical_device_config_reg_in[3:2];
    wire idle = !core_reset_out;
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dor_rst_q <= 1'b1;
        end else if (dor_wr_in) begin
            dor_rst_q <= !dor_data_in[2];
        end
    end
    a_st2_fixed_zero: assert property ((result_status_two_out & 8'h8C) == 8'h00)
        else $error("status two fixed bits set");
    a_st3_pin_view: assert property (
        (result_status_three_out & 8'hAF) == {5'h05, head_sel_in, drive_sel_in})
        else $error("status three fixed or pin bits wrong");
    a_crc_flag_set: assert property (
        ev_crc_bad_in && idle |=> result_status_two_out[5])
        else $error("crc flag not set");
    a_track_flags_set: assert property (
        ev_id_in && idle && id_track_in != kept_track_in |=> result_status_two_out[4] &&
        (result_status_two_out[1] || $past(id_track_in) != 8'hFF))
        else $error("track flags not set");
    a_no_mark_set: assert property (ev_no_mark_in && idle |=> result_status_two_out[0])
        else $error("missing mark flag not set");
    a_rqm_drop_busy: assert property (
        cmd_wr_in && request_for_master_flag_out && !transfer_direction_flag_out && idle
        |=> !request_for_master_flag_out [*3])
        else $error("request flag not low after byte");
    a_dor_reset_held: assert property (dor_rst_q |-> core_reset_out)
        else $error("core not in reset while output reset bit set");
    a_dsr_self_clear: assert property (
        dsr_wr_in && dsr_reset_in && !dor_rst_q && !dor_wr_in
        |-> ##[0:1] core_reset_out ##[1:2] !core_reset_out)
        else $error("rate reset did not pulse");
    a_density_polarity: assert property (
        mode != 2'h3 && !$past(rst_in) && $stable(logical_device_config_reg_in) &&
        $stable(high_density_in)
        |-> density_select_output_out == (high_density_in ^ (mode != 2'h0)))
        else $error("density polarity wrong");
    a_burst_select: assert property (burst_mode_out == logical_device_config_reg_in[1])
        else $error("burst mode not from config bit");
endmodule // fcs_core_props
bind fcs_core fcs_core_props u_fcs_core_props (.*);

// >>> sim/fcs_host_model.sv
`timescale 1ns/100ps
module fcs_host_model (
    // clock
    input wire clk_sys_in,
    // phase flags
    input wire request_for_master_flag_in,
    input wire transfer_direction_flag_in,
    // byte strobes
    output reg cmd_wr_out,
    output reg [7:0] cmd_data_out,
    output reg result_rd_out
);
    integer n;
    initial begin
        cmd_wr_out = 1'b0;
        cmd_data_out = 8'h00;
        result_rd_out = 1'b0;
    end
    // one byte once the flags allow it; ok stays low if they do not within 60 clocks
    task xfer(input rd, input [7:0] b, output ok);
        begin
            ok = 1'b0;
            for (n = 0; n < 60 && !ok; n = n + 1) begin
                @(posedge clk_sys_in);
                #1;
                ok = request_for_master_flag_in === 1'b1 && transfer_direction_flag_in === rd;
            end
            if (ok) begin
                cmd_data_out = b;
                cmd_wr_out = !rd;
                result_rd_out = rd;
                @(posedge clk_sys_in);
                #1;
                cmd_wr_out = 1'b0;
                result_rd_out = 1'b0;
                // released data bus does not keep the last byte
                cmd_data_out = ~b;
            end
        end
    endtask
endmodule // fcs_host_model

// >>> sim/fcs_core_tb.sv
`timescale 1ns/100ps
module fcs_core_tb;
    reg clk_sys_in, rst_in, dor_wr_in, dsr_wr_in, dsr_reset_in, cfg_load_in, cfg_fifo_en_in;
    reg cfg_poll_off_in, spec_load_in, spec_dma_in, exec_done_in, ev_mark_kind_in;
    reg read_deleted_in, ev_crc_bad_in, ev_id_in, ev_no_mark_in, to_host_in, sector_last_in;
    reg irq_raw_in, write_protect_in, track_zero_input_in, head_sel_in, high_density_in, ok;
    reg [7:0] dor_data_in, logical_device_config_reg_in, id_track_in, kept_track_in;
    reg [3:0] cfg_thr_in;
    reg [4:0] fifo_level_in;
    reg [1:0] drive_sel_in;
    wire cmd_wr_in, result_rd_in, request_for_master_flag_out, transfer_direction_flag_out;
    wire core_reset_out, power_down_exit_out, polling_on_out, dma_request_out, irq_out;
    wire burst_mode_out, density_select_output_out;
    wire [7:0] cmd_data_in, result_status_two_out, result_status_three_out;
    wire [4:0] threshold_out;
    integer errors, checks_done, k;
    fcs_core u_fcs_core (.*);
    fcs_host_model u_fcs_host_model (.clk_sys_in(clk_sys_in),
        .request_for_master_flag_in(request_for_master_flag_out),
        .transfer_direction_flag_in(transfer_direction_flag_out),
        .cmd_wr_out(cmd_wr_in), .cmd_data_out(cmd_data_in), .result_rd_out(result_rd_in));
    always #5 clk_sys_in = ~clk_sys_in;
    task tick(input integer c);
        repeat (c) begin
            @(posedge clk_sys_in);
            #1;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (errors == 0 && checks_done > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    task flags(input [1:0] e);
        check({6'h00, request_for_master_flag_out, transfer_direction_flag_out}, {6'h00, e});
    endtask
    task hw_reset;
        begin
            rst_in = 1'b1;
            tick(5);
            rst_in = 1'b0;
        end
    endtask
    task digital_output_register(input [7:0] v);
        begin
            dor_data_in = v;
            dor_wr_in = 1'b1;
            tick(1);
            dor_wr_in = 1'b0;
        end
    endtask
    task dsr;
        begin
            dsr_reset_in = 1'b1;
            dsr_wr_in = 1'b1;
            tick(1);
            check({6'h00, core_reset_out, power_down_exit_out}, 8'h03);
            dsr_wr_in = 1'b0;
            tick(4);
        end
    endtask
    task cfg(input [3:0] t);
        begin
            tick(1);
            cfg_thr_in = t;
            cfg_load_in = 1'b1;
            tick(1);
            cfg_load_in = 1'b0;
        end
    endtask
    task ev(input [3:0] sel, input [7:0] exp);
        begin
            tick(1);
            {ev_mark_kind_in, ev_crc_bad_in, ev_id_in, ev_no_mark_in} = sel;
            tick(1);
            {ev_mark_kind_in, ev_crc_bad_in, ev_id_in, ev_no_mark_in} = 4'h0;
            check(result_status_two_out, exp);
        end
    endtask
    task xfer(input rd, input [7:0] b);
        begin
            u_fcs_host_model.xfer(rd, b, ok);
            if (!ok) begin
                errors = errors + 1;
                finish_test;
            end
        end
    endtask
    task cmd_start(input [7:0] op, input integer np);
        integer j;
        begin
            xfer(1'b0, op);
            for (j = 0; j < np; j = j + 1) xfer(1'b0, 8'hA5);
            tick(6);
            flags(2'h0);
        end
    endtask
    task cmd_end(input integer nr);
        integer j;
        begin
            exec_done_in = 1'b1;
            tick(1);
            exec_done_in = 1'b0;
            for (j = 0; j < nr; j = j + 1) xfer(1'b1, 8'h00);
            tick(2);
            flags(2'h2);
        end
    endtask
    task dreq(input [4:0] lvl, input last, input [7:0] e);
        begin
            fifo_level_in = lvl;
            sector_last_in = last;
            tick(3);
            check({7'h00, dma_request_out}, e);
        end
    endtask
    initial begin
        {clk_sys_in, dor_wr_in, dsr_wr_in, dsr_reset_in, cfg_load_in, cfg_poll_off_in} = '0;
        {spec_load_in, spec_dma_in, exec_done_in, ev_mark_kind_in, read_deleted_in} = '0;
        {ev_crc_bad_in, ev_id_in, ev_no_mark_in, to_host_in, sector_last_in, irq_raw_in} = '0;
        {write_protect_in, track_zero_input_in, head_sel_in, high_density_in, drive_sel_in} = '0;
        {dor_data_in, logical_device_config_reg_in, cfg_thr_in, fifo_level_in} = '0;
        {id_track_in, kept_track_in} = {8'h05, 8'h03};
        cfg_fifo_en_in = 1'b1;
        rst_in = 1'b1;
        errors = 0;
        checks_done = 0;
        hw_reset;
        check({4'h0, core_reset_out, request_for_master_flag_out,
            transfer_direction_flag_out, density_select_output_out}, 8'h0D);
        check(result_status_two_out, 8'h00);
        spec_dma_in = 1'b1;
        spec_load_in = 1'b1;
        tick(1);
        spec_load_in = 1'b0;
        digital_output_register(8'h0C);
        check({6'h00, core_reset_out, polling_on_out}, 8'h01);
        for (k = 0; k < 8; k = k + 1) begin
            {head_sel_in, drive_sel_in} = k[2:0];
            {track_zero_input_in, write_protect_in} = k[1:0];
            tick(5);
            check(result_status_three_out, {1'b0, k[0], 1'b1, k[1], 1'b1, k[2:0]});
        end
        // pin reset in the middle of a command
        cmd_start(8'h03, 2);
        hw_reset;
        check({4'h0, core_reset_out, request_for_master_flag_out,
            transfer_direction_flag_out, density_select_output_out}, 8'h0D);
        digital_output_register(8'h0C);
        for (k = 0; k < 16; k = k + 1) begin
            cfg(k[3:0]);
            check({3'h0, threshold_out}, k[7:0] + 8'h01);
        end
        cfg(4'h3);
        ev(4'h4, 8'h20);
        ev(4'h2, 8'h30);
        id_track_in = 8'hFF;
        ev(4'h2, 8'h32);
        ev(4'h1, 8'h33);
        ev(4'h8, 8'h73);
        cmd_start(8'h08, 0);
        check(result_status_two_out, 8'h00);
        dreq(5'h00, 1'b0, 8'h01);
        dreq(5'h10, 1'b0, 8'h00);
        to_host_in = 1'b1;
        dreq(5'h0B, 1'b0, 8'h00);
        dreq(5'h0C, 1'b0, 8'h01);
        dreq(5'h00, 1'b0, 8'h00);
        dreq(5'h02, 1'b1, 8'h01);
        irq_raw_in = 1'b1;
        for (k = 0; k < 6; k = k + 1) begin
            digital_output_register({4'h0, k[0], 3'h4});
            logical_device_config_reg_in = {4'h0, k[2:1], k[0], 1'b0};
            high_density_in = k[0];
            tick(3);
            check({4'h0, burst_mode_out, dma_request_out, irq_out, density_select_output_out},
                {4'h0, k[0], {2{k[0] | (k[2:1] == 2'h1)}}, k[0] ^ (k[2:1] != 2'h0)});
        end
        {irq_raw_in, to_host_in, sector_last_in, logical_device_config_reg_in} = '0;
        digital_output_register(8'h0C);
        cmd_end(7);
        xfer(1'b0, 8'h00);
        xfer(1'b1, 8'h00);
        tick(2);
        flags(2'h2);
        cmd_start(8'h13, 3);
        cmd_end(7);
        cmd_start(8'h06, 8);
        cmd_end(7);
        dsr;
        check({6'h00, core_reset_out, request_for_master_flag_out}, 8'h01);
        cfg_poll_off_in = 1'b1;
        cfg(4'h0);
        check({7'h00, polling_on_out}, 8'h00);
        digital_output_register(8'h08);
        dsr;
        check({7'h00, core_reset_out}, 8'h01);
        digital_output_register(8'h0C);
        tick(2);
        check({6'h00, core_reset_out, polling_on_out}, 8'h01);
        finish_test;
    end
endmodule // fcs_core_tb
